/* File: verilog/spi_port_consts.svh */
// Purpose: Constants for the SPI-mode serial port.
// Assumes: 25 MHz reference clock.
// Notes:   Timing counts are in reference clock cycles.
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// ----------------------------------------
// Word and FIFO geometry
// ----------------------------------------
`define SPI_WORD_BITS      8
`define SPI_FIFO_DEPTH     4
`define SPI_FIFO_AW        2

// ----------------------------------------
// Baud generator and dummy transmit word
// ----------------------------------------
`define SPI_PRESCALE_W     5
`define SPI_DIVIDER_W      3
`define SPI_PRESCALE_INIT  5'h00
`define SPI_DIVIDER_INIT   3'h7
`define SPI_TX_DUMMY       8'hFF

`endif

/* File: verilog/spi_port_pkg.sv */
// Purpose: Types for the SPI-mode serial port.
// Assumes: Used with spi_port_consts.svh.
// Notes:   States only; numbers live in the header.
package spi_port_pkg;

   // ----------------------------------------
   // Shifter states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LEAD  = 2'b01,
      ST_SHIFT = 2'b10,
      ST_GAP   = 2'b11
   } shift_state_t;

endpackage : spi_port_pkg

/* File: verilog/spi_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, flush clears pointers.
// Notes:   Read data comes from a register.
`timescale 1ns/100ps
module spi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4,
   parameter int AW    = 2
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             flush_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o,
   // Status
   output logic      [AW:0]      level_o
);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0]      cnt_ff, nxt_cnt;
   logic [WIDTH-1:0] dout_ff, nxt_dout;
   logic             push, pop;

   // ----------------------------------------
   // Handshake
   // ----------------------------------------
   assign in_ready_o  = (cnt_ff != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid_o = (cnt_ff != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = dout_ff;
   assign level_o     = cnt_ff;

   // Next pointers and head data
   always_comb begin
      nxt_wr   = wr_ff;
      nxt_rd   = rd_ff;
      nxt_cnt  = cnt_ff;
      nxt_dout = mem_ff[rd_ff];
      if (flush_i) begin
         nxt_wr  = '0;
         nxt_rd  = '0;
         nxt_cnt = '0;
      end else begin
         if (push) nxt_wr = wr_ff + 1'b1;
         if (pop) nxt_rd = rd_ff + 1'b1;
         if (push && !pop) nxt_cnt = cnt_ff + 1'b1;
         if (pop && !push) nxt_cnt = cnt_ff - 1'b1;
         if (push && (cnt_ff == '0 || (pop && cnt_ff == (AW+1)'(1))))
            nxt_dout = in_data_i;
         else
            nxt_dout = mem_ff[nxt_rd];
      end
   end

   // Pointer registers
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ff   <= '0;
         rd_ff   <= '0;
         cnt_ff  <= '0;
         dout_ff <= '0;
      end else begin
         wr_ff   <= nxt_wr;
         rd_ff   <= nxt_rd;
         cnt_ff  <= nxt_cnt;
         dout_ff <= nxt_dout;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge ref_clk_i) begin
      if (push && !flush_i) mem_ff[wr_ff] <= in_data_i;
   end

endmodule : spi_fifo

/* File: verilog/spi_port_master.sv */
// Purpose: SPI-mode fixed master of a FIFO-buffered serial port.
// Assumes: Inputs synchronous to ref_clk_i; one clock domain.
// Notes:   Control bits are plain ports; no register bus.
// Function
// - Words are fixed at 8 bits, data in upper byte of data registers.
// - Master exchanges 8-bit words one at a time; slave select frames each word.
// - Only transmit and receive DMA requests exist, each gated by its enable.
// - Receive-only DMA mode sends dummy data and fills receive FIFO.
// - Receive continues while enabled; full FIFO sets overflow, drops words.
// - CPU transmit mode shifts FIFO out, ignores MISO, ends when empty.
// - DMA transmit mode sends DMA-loaded words, ignores MISO, ends when empty.
// - Receive-only: MOSI is 1, or released when idle-output bit set.
// - Four formats by clock phase and clock polarity.
// - Generator enable starts baud generator; clock pin idles until transfer.
// - Frame sync enable initialises frame state and slave select.
// - Transmit modes start only after transmit data is written.
// - DMA receive starts as soon as receive enable is set.
// - Full duplex sends and receives together, framed by slave select.
// - Transmit FIFO empty means all queued words fully exchanged.
// - Unit resets clear data register, pointers, flags and enable bit; receive unit reset does not clear rx_data_reg_o.
// - Interrupt rises when any source and its enable are both 1.
// - Full transmit FIFO ignores writes; empty receive read is undefined.
`timescale 1ns/100ps
`include "spi_port_consts.svh"
module spi_port_master #(
   parameter int DEPTH = `SPI_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   // Control bits
   input  wire logic        clock_gen_enable_i,
   input  wire logic        frame_sync_enable_i,
   input  wire logic        tx_enable_bit_set_i,
   input  wire logic        tx_enable_bit_clr_i,
   input  wire logic        rx_enable_bit_set_i,
   input  wire logic        rx_enable_bit_clr_i,
   input  wire logic        tx_unit_reset_i,
   input  wire logic        rx_unit_reset_i,
   input  wire logic        tx_dma_enable_i,
   input  wire logic        rx_dma_enable_i,
   input  wire logic        idle_output_hiz_i,
   input  wire logic        cpol_i,
   input  wire logic        cpha_i,
   input  wire logic [4:0]  prescale_field_i,
   input  wire logic [2:0]  divider_field_i,
   input  wire logic [4:0]  irq_enable_reg_i,
   // Data registers
   input  wire logic        tx_data_wr_i,
   input  wire logic [15:0] tx_data_reg_i,
   input  wire logic        rx_data_rd_i,
   output logic      [15:0] rx_data_reg_o,
   // Status
   output logic             tx_enable_bit_o,
   output logic             rx_enable_bit_o,
   output logic             tx_transfer_request_o,
   output logic             tx_fifo_empty_flag_o,
   output logic             rx_transfer_request_o,
   output logic             rx_fifo_full_flag_o,
   output logic             rx_fifo_overflow_flag_o,
   output logic             irq_o,
   output logic             tx_dma_request_o,
   output logic             rx_dma_request_o,
   // SPI pins
   output logic             sck_o,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        miso_i,
   output logic             slave_select_0_n_o
);

   localparam int W  = `SPI_WORD_BITS;
   localparam int AW = $clog2(DEPTH);

   logic                      txe_ff, nxt_txe, rxe_ff, nxt_rxe, ovf_ff, nxt_ovf;
   logic [7:0]                txd_ff, nxt_txd;
   logic                      tf_in_rdy, tf_out_val, tf_pop;
   logic [W-1:0]              tf_out;
   logic                      rf_in_rdy, rf_out_val, rf_push;
   logic [W-1:0]              rf_out;
   logic [AW:0]               tf_lvl;
   logic                      rx_only;
   logic [7:0]                baud_ff, nxt_baud, limit;
   logic                      tick;
   spi_port_pkg::shift_state_t st_ff, nxt_st;
   logic [3:0]                edge_ff, nxt_edge;
   logic [7:0]                sh_ff, nxt_sh, rsh_ff, nxt_rsh;
   logic                      sck_ff, nxt_sck, ss_ff, nxt_ss, busy_ff, nxt_busy;
   logic                      is_rx_ff, nxt_is_rx;

   // Baud divide: (prescale+1) * 2^(7-divider), capped at 8 bits
   function automatic logic [7:0] baud_limit(input logic [4:0] p, input logic [2:0] d);
      logic [12:0] v;
      v = 13'((p + 6'h01)) << (3'h7 - d);
      baud_limit = (v > 13'h00FF) ? 8'hFF : 8'(v - 13'h0001);
   endfunction : baud_limit

   // ----------------------------------------
   // FIFOs
   // ----------------------------------------
   spi_fifo #(.WIDTH(W), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
      .ref_clk_i  (ref_clk_i),
      .reset_n_i  (reset_n_i),
      .flush_i    (tx_unit_reset_i),
      .in_valid_i (tx_data_wr_i),
      .in_ready_o (tf_in_rdy),
      .in_data_i  (tx_data_reg_i[15:8]),
      .out_valid_o(tf_out_val),
      .out_ready_i(tf_pop),
      .out_data_o (tf_out),
      .level_o    (tf_lvl)
   );

   spi_fifo #(.WIDTH(W), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
      .ref_clk_i  (ref_clk_i),
      .reset_n_i  (reset_n_i),
      .flush_i    (rx_unit_reset_i),
      .in_valid_i (rf_push),
      .in_ready_o (rf_in_rdy),
      .in_data_i  (rsh_ff),
      .out_valid_o(rf_out_val),
      .out_ready_i(rx_data_rd_i),
      .out_data_o (rf_out),
      .level_o    ()
   );

   // ----------------------------------------
   // Enables, last written word, overflow
   // ----------------------------------------
   assign rx_only = rxe_ff & ~txe_ff;

   // Next enable and flag values
   always_comb begin
      nxt_txe = txe_ff;
      nxt_rxe = rxe_ff;
      nxt_txd = txd_ff;
      nxt_ovf = ovf_ff;
      if (tx_enable_bit_set_i) nxt_txe = 1'b1;
      if (tx_enable_bit_clr_i) nxt_txe = 1'b0;
      if (rx_enable_bit_set_i) nxt_rxe = 1'b1;
      if (rx_enable_bit_clr_i) nxt_rxe = 1'b0;
      if (tx_data_wr_i && tf_in_rdy) nxt_txd = tx_data_reg_i[15:8];
      if (rf_push && !rf_in_rdy) nxt_ovf = 1'b1;
      if (tx_unit_reset_i) begin
         nxt_txe = 1'b0;
         nxt_txd = '0;
      end
      if (rx_unit_reset_i) begin
         nxt_rxe = 1'b0;
         nxt_ovf = 1'b0;
      end
   end

   // Enable and flag registers
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         txe_ff <= 1'b0;
         rxe_ff <= 1'b0;
         txd_ff <= '0;
         ovf_ff <= 1'b0;
      end else begin
         txe_ff <= nxt_txe;
         rxe_ff <= nxt_rxe;
         txd_ff <= nxt_txd;
         ovf_ff <= nxt_ovf;
      end
   end

   // ----------------------------------------
   // Baud generator
   // ----------------------------------------
   assign limit = baud_limit(prescale_field_i, divider_field_i);
   assign tick  = clock_gen_enable_i && (baud_ff >= limit);  // Recovers when limit shrinks

   // Runs only with generator enable
   always_comb begin
      nxt_baud = baud_ff;
      if (!clock_gen_enable_i || tick) nxt_baud = '0;
      else nxt_baud = baud_ff + 8'h01;
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) baud_ff <= '0;
      else baud_ff <= nxt_baud;
   end

   // ----------------------------------------
   // Shifter
   // ----------------------------------------
   assign tf_pop  = (st_ff == spi_port_pkg::ST_IDLE) && tick && frame_sync_enable_i
                    && txe_ff && tf_out_val;
   // Word is whole only at the gap tick, after the last sample in either phase
   assign rf_push = (st_ff == spi_port_pkg::ST_GAP) && tick && is_rx_ff
                    && !rx_unit_reset_i;

   // Next shifter state
   always_comb begin
      nxt_st    = st_ff;
      nxt_edge  = edge_ff;
      nxt_sh    = sh_ff;
      nxt_rsh   = rsh_ff;
      nxt_sck   = sck_ff;
      nxt_ss    = ss_ff;
      nxt_busy  = busy_ff;
      nxt_is_rx = is_rx_ff;
      unique case (st_ff)
         spi_port_pkg::ST_IDLE: begin
            nxt_sck  = cpol_i;
            nxt_busy = 1'b0;
            if (tick && frame_sync_enable_i) begin
               if (txe_ff && tf_out_val) begin
                  nxt_sh    = tf_out;
                  nxt_is_rx = rxe_ff;
                  nxt_st    = spi_port_pkg::ST_LEAD;
                  nxt_busy  = 1'b1;
               end else if (rx_only && rx_dma_enable_i) begin
                  nxt_sh    = `SPI_TX_DUMMY;
                  nxt_is_rx = 1'b1;
                  nxt_st    = spi_port_pkg::ST_LEAD;
                  nxt_busy  = 1'b1;
               end
            end
         end
         spi_port_pkg::ST_LEAD: if (tick) begin
            nxt_ss   = 1'b1;
            nxt_edge = '0;
            nxt_st   = spi_port_pkg::ST_SHIFT;
         end
         spi_port_pkg::ST_SHIFT: if (tick) begin
            nxt_sck  = ~sck_ff;
            nxt_edge = edge_ff + 4'h1;
            // Sample edge is odd for phase 1, even for phase 0
            if (edge_ff[0] == cpha_i)
               nxt_rsh = {rsh_ff[6:0], miso_i};
            else if (edge_ff != 4'h0)                  // First bit already out
               nxt_sh = {sh_ff[6:0], 1'b0};
            if (edge_ff == 4'hF) nxt_st = spi_port_pkg::ST_GAP;
         end
         spi_port_pkg::ST_GAP: if (tick) begin
            nxt_ss = 1'b0;
            nxt_st = spi_port_pkg::ST_IDLE;
         end
         // All four state codes are legal, so no default
      endcase
      if (!frame_sync_enable_i || tx_unit_reset_i || rx_unit_reset_i) begin
         nxt_st   = spi_port_pkg::ST_IDLE;
         nxt_ss   = 1'b0;
         nxt_sck  = cpol_i;
         nxt_busy = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff    <= spi_port_pkg::ST_IDLE;
         edge_ff  <= '0;
         sh_ff    <= '0;
         rsh_ff   <= '0;
         sck_ff   <= 1'b0;
         ss_ff    <= 1'b0;
         busy_ff  <= 1'b0;
         is_rx_ff <= 1'b0;
      end else begin
         st_ff    <= nxt_st;
         edge_ff  <= nxt_edge;
         sh_ff    <= nxt_sh;
         rsh_ff   <= nxt_rsh;
         sck_ff   <= nxt_sck;
         ss_ff    <= nxt_ss;
         busy_ff  <= nxt_busy;
         is_rx_ff <= nxt_is_rx;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Pins; MOSI idles high or released when transmit is off
   assign sck_o              = ss_ff ? sck_ff : cpol_i;
   assign slave_select_0_n_o = ~ss_ff;
   assign mosi_o             = ss_ff && txe_ff ? sh_ff[7] : 1'b1;
   assign mosi_oe_o          = ~(rx_only && idle_output_hiz_i);
   assign rx_data_reg_o      = {rf_out, 8'h00};

   // Status; empty only once shifter is done too
   assign tx_enable_bit_o         = txe_ff;
   assign rx_enable_bit_o         = rxe_ff;
   assign tx_fifo_empty_flag_o    = (tf_lvl == '0) && !busy_ff;
   assign tx_transfer_request_o   = txe_ff && tf_in_rdy;
   assign rx_transfer_request_o   = rxe_ff && rf_out_val;
   assign rx_fifo_full_flag_o     = !rf_in_rdy;
   assign rx_fifo_overflow_flag_o = ovf_ff;
   assign irq_o = |({tx_transfer_request_o, tx_fifo_empty_flag_o, rx_transfer_request_o,
                     rx_fifo_full_flag_o, ovf_ff} & irq_enable_reg_i);
   assign tx_dma_request_o = tx_transfer_request_o && tx_dma_enable_i;
   assign rx_dma_request_o = rx_transfer_request_o && rx_dma_enable_i;

endmodule : spi_port_master

/* File: verification/spi_port_master_asserts.sv */
// Purpose: Port-level assertions for the SPI-mode master.
// Assumes: Bound to every instance of spi_port_master.
// Notes:   One clock domain, asynchronous active-low reset.
`timescale 1ns/100ps
module spi_port_master_asserts (
   // Clock, reset and control
   input wire logic       ref_clk_i, reset_n_i, clock_gen_enable_i,
   input wire logic       frame_sync_enable_i, tx_unit_reset_i, rx_unit_reset_i,
   input wire logic       tx_dma_enable_i, rx_dma_enable_i, idle_output_hiz_i, cpol_i,
   input wire logic [4:0] irq_enable_reg_i,
   // Status and pins
   input wire logic       tx_enable_bit_o, rx_enable_bit_o, tx_transfer_request_o,
   input wire logic       tx_fifo_empty_flag_o, rx_transfer_request_o, rx_fifo_full_flag_o,
   input wire logic       rx_fifo_overflow_flag_o, irq_o, tx_dma_request_o,
   input wire logic       rx_dma_request_o, sck_o, mosi_o, mosi_oe_o, slave_select_0_n_o
);
   // --------------------------------
   // Properties
   // --------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   logic rx_only;
   assign rx_only = rx_enable_bit_o && !tx_enable_bit_o && rx_dma_enable_i;

   idle_clk_a: assert property (slave_select_0_n_o && $past(slave_select_0_n_o)
      && $stable(cpol_i) |-> sck_o == cpol_i) else $error("sck not idle");
   irq_map_a: assert property (irq_o == |({tx_transfer_request_o, tx_fifo_empty_flag_o,
      rx_transfer_request_o, rx_fifo_full_flag_o, rx_fifo_overflow_flag_o} & irq_enable_reg_i))
      else $error("irq mismatch");
   dma_gate_a: assert property (!(tx_dma_request_o && !tx_dma_enable_i)
      && !(rx_dma_request_o && !rx_dma_enable_i)) else $error("dma request not enabled");
   fse_off_a: assert property (!frame_sync_enable_i [*2] |-> slave_select_0_n_o)
      else $error("select active without frame sync");
   hiz_idle_a: assert property ((rx_only && idle_output_hiz_i) [*3] |-> !mosi_oe_o)
      else $error("mosi driven");
   drive_one_a: assert property ((rx_only && !idle_output_hiz_i) [*3]
      |-> mosi_oe_o && mosi_o) else $error("mosi not high");
   busy_flag_a: assert property (tx_enable_bit_o && !slave_select_0_n_o
      && sck_o != cpol_i |-> !tx_fifo_empty_flag_o) else $error("empty during shift");
   start_data_a: assert property ($fell(slave_select_0_n_o) && tx_enable_bit_o
      |-> !tx_fifo_empty_flag_o) else $error("start without data");
   gen_off_a: assert property (!clock_gen_enable_i && !$past(clock_gen_enable_i)
      && $stable(cpol_i) |-> $stable(sck_o)) else $error("sck moves");
   ovf_hold_a: assert property (rx_fifo_overflow_flag_o && !rx_unit_reset_i
      |=> rx_fifo_overflow_flag_o) else $error("overflow lost");
   ovf_cause_a: assert property ($rose(rx_fifo_overflow_flag_o)
      |-> $past(rx_fifo_full_flag_o)) else $error("overflow without full");
   tx_rst_a: assert property (tx_unit_reset_i |=> tx_fifo_empty_flag_o
      && !tx_enable_bit_o) else $error("tx reset");
   rx_rst_a: assert property (rx_unit_reset_i |=> !rx_fifo_full_flag_o
      && !rx_enable_bit_o && !rx_fifo_overflow_flag_o) else $error("rx reset");
   cover property ($fell(slave_select_0_n_o) && tx_enable_bit_o && rx_enable_bit_o);
   cover property ($rose(rx_fifo_overflow_flag_o));
   cover property (rx_only && !mosi_oe_o);
endmodule : spi_port_master_asserts
bind spi_port_master spi_port_master_asserts i_chk (.*);

/* File: verification/spi_slave_model.sv */
// Purpose: Behavioural SPI slave facing the master.
// Assumes: One word per select-low period, MSB first.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/100ps
module spi_slave_model (
   input  wire logic       sck_i,
   input  wire logic       ss_n_i,
   input  wire logic       mosi_i,
   input  wire logic       cpol_i,
   input  wire logic       cpha_i,
   input  wire logic [7:0] tx_byte_i,
   output logic            miso_o,
   output logic      [7:0] rx_byte_o,
   output int              words_o
);
   logic [7:0] tx_sr;
   logic [7:0] rx_sr;
   int         nbits;
   initial begin
      miso_o = 1'h0;
      words_o = 0;
   end
   // Select low loads the word, select high releases the line
   always @(ss_n_i) begin
      if (!ss_n_i) begin
         tx_sr = tx_byte_i;
         nbits = 0;
         if (!cpha_i) begin
            miso_o = tx_sr[7];
            tx_sr = {tx_sr[6:0], 1'h0};
         end
      end else begin
         miso_o = ~miso_o;
      end
   end
   // Sample on one clock edge, launch on the other
   always @(sck_i) begin
      if (!ss_n_i && ((sck_i != cpol_i) ^ cpha_i)) begin
         rx_sr = {rx_sr[6:0], mosi_i};
         nbits++;
         if (nbits == 8) begin
            rx_byte_o = rx_sr;
            words_o++;
         end
      end else if (!ss_n_i) begin
         miso_o = tx_sr[7];
         tx_sr = {tx_sr[6:0], 1'h0};
      end
   end
endmodule : spi_slave_model

/* File: verification/spi_port_master_tb.sv */
// Purpose: Self-checking bench for the SPI-mode master.
// Assumes: Half bit of four clocks keeps words short.
// Notes:   Inputs move 1 ns after the rising clock edge.
`timescale 1ns/100ps
module spi_port_master_tb;
   logic ref_clk_i, reset_n_i = 1'h0, clock_gen_enable_i = 1'h0, frame_sync_enable_i = 1'h0;
   logic tx_enable_bit_set_i = 1'h0, tx_enable_bit_clr_i = 1'h0, rx_enable_bit_set_i = 1'h0;
   logic rx_enable_bit_clr_i = 1'h0, tx_unit_reset_i = 1'h0, rx_unit_reset_i = 1'h0;
   logic tx_dma_enable_i = 1'h0, rx_dma_enable_i = 1'h0, idle_output_hiz_i = 1'h0;
   logic cpol_i = 1'h0, cpha_i = 1'h0, tx_data_wr_i = 1'h0, rx_data_rd_i = 1'h0, miso_i;
   logic [4:0] prescale_field_i = 5'h01, irq_enable_reg_i = 5'h00;
   logic [2:0] divider_field_i = 3'h6;
   logic [15:0] tx_data_reg_i = 16'h0000, rx_data_reg_o;
   logic tx_enable_bit_o, rx_enable_bit_o, tx_transfer_request_o, tx_fifo_empty_flag_o;
   logic rx_transfer_request_o, rx_fifo_full_flag_o, rx_fifo_overflow_flag_o, irq_o;
   logic tx_dma_request_o, rx_dma_request_o, sck_o, mosi_o, mosi_oe_o, slave_select_0_n_o;
   wire mosi_w;
   logic [7:0] sb = 8'h5A, sl_rx;
   int words, base, bad_count, check_count;
   assign mosi_w = mosi_oe_o ? mosi_o : ~mosi_o;
   spi_port_master #(.DEPTH(4)) i_dut (.*);
   spi_slave_model i_slave (.sck_i(sck_o), .ss_n_i(slave_select_0_n_o), .mosi_i(mosi_w),
      .cpol_i(cpol_i), .cpha_i(cpha_i), .tx_byte_i(sb), .miso_o(miso_i), .rx_byte_o(sl_rx),
      .words_o(words));
   // --------------------------------
   // Clock and helpers
   // --------------------------------
   initial begin
      ref_clk_i = 1'h0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   function automatic logic cond(input int s);
      case (s)
         0: return tx_fifo_empty_flag_o === 1'h1 && slave_select_0_n_o === 1'h1;
         1: return rx_fifo_overflow_flag_o === 1'h1;
         2: return tx_dma_request_o === 1'h1;
         3: return slave_select_0_n_o === 1'h0;
         default: return words != base;
      endcase
   endfunction : cond
   task automatic wait_on(input int s);
      int n;
      n = 0;
      while (!cond(s) && n < 4000) begin
         tick(1);
         n++;
      end
      if (n == 4000) begin
         bad_count++;
         $display("CHECK FAILED at %0t: wait %0d timed out", $time, s);
         test_done();
      end
   endtask : wait_on
   task automatic wr(input logic [7:0] b);
      tx_data_wr_i = 1'h1;
      tx_data_reg_i = {b, 8'h00};
      tick(1);
   endtask : wr
   task automatic pop_chk(input logic [7:0] exp);
      chk(rx_data_reg_o[15:8], exp, "rx word");
      rx_data_rd_i = 1'h1;
      tick(1);
      rx_data_rd_i = 1'h0;
      tick(2);
   endtask : pop_chk
   task automatic cfg(input logic td, input logic rdm);
      tx_dma_enable_i = td;
      rx_dma_enable_i = rdm;
      tick(1);
      frame_sync_enable_i = 1'h1;
      tick(1);
   endtask : cfg
   task automatic go(input logic t, input logic r);
      tx_enable_bit_set_i = t;
      rx_enable_bit_set_i = r;
      tick(1);
      tx_enable_bit_set_i = 1'h0;
      rx_enable_bit_set_i = 1'h0;
   endtask : go
   // Shutdown: enables off, frame sync off, generator and units reset
   task automatic stop;
      tx_enable_bit_clr_i = 1'h1;
      rx_enable_bit_clr_i = 1'h1;
      tick(1);
      tx_enable_bit_clr_i = 1'h0;
      rx_enable_bit_clr_i = 1'h0;
      frame_sync_enable_i = 1'h0;
      prescale_field_i = 5'h00;
      divider_field_i = 3'h7;
      tick(1);
      tx_unit_reset_i = 1'h1;
      rx_unit_reset_i = 1'h1;
      tick(1);
      tx_unit_reset_i = 1'h0;
      rx_unit_reset_i = 1'h0;
      prescale_field_i = 5'h01;
      divider_field_i = 3'h6;
      tick(1);
   endtask : stop
   // --------------------------------
   // Scenarios
   // --------------------------------
   initial begin
      tick(12);
      reset_n_i = 1'h1;
      tick(4);
      chk({slave_select_0_n_o, tx_fifo_empty_flag_o, sck_o}, 3'h6, "reset");
      clock_gen_enable_i = 1'h1;
      // Full duplex in all four formats, five writes into four places
      for (int f = 0; f < 4; f++) begin
         cpol_i = f[1];
         cpha_i = f[0];
         sb = 8'h5A + 8'(f);
         irq_enable_reg_i = 5'h02;
         cfg(1'h0, 1'h0);
         for (int i = 0; i < 5; i++) begin
            wr(8'h81 + 8'(16 * f + i));
         end
         tx_data_wr_i = 1'h0;
         base = words;
         go(1'h1, 1'h1);
         wait_on(0);
         chk(16'(words - base), 16'h0004, "word count");
         chk(sl_rx, 8'h84 + 8'(16 * f), "slave byte");
         chk({rx_fifo_full_flag_o, irq_o}, 2'h3, "rx full");
         for (int i = 0; i < 4; i++) begin
            pop_chk(sb);
         end
         stop();
      end
      // Transmit only by the processor
      cfg(1'h0, 1'h0);
      go(1'h1, 1'h0);
      tick(20);
      chk({slave_select_0_n_o, tx_enable_bit_o, tx_transfer_request_o, rx_enable_bit_o},
         4'hE, "early start");
      base = words;
      wr(8'hC3);
      wr(8'h96);
      tx_data_wr_i = 1'h0;
      wait_on(0);
      chk({8'(words - base), sl_rx}, 16'h0296, "tx only");
      chk({rx_fifo_full_flag_o, rx_transfer_request_o, tx_dma_request_o}, 3'h0, "quiet");
      stop();
      // Transmit fed on request
      cfg(1'h1, 1'h0);
      go(1'h1, 1'h0);
      base = words;
      for (int i = 0; i < 2; i++) begin
         wait_on(2);
         wr(8'h3C + 8'(i));
         tx_data_wr_i = 1'h0;
         tick(1);
      end
      wait_on(0);
      chk({8'(words - base), sl_rx}, 16'h023D, "dma tx");
      stop();
      // Receive only with released line until overflow
      idle_output_hiz_i = 1'h1;
      irq_enable_reg_i = 5'h01;
      cfg(1'h0, 1'h1);
      go(1'h0, 1'h1);
      wait_on(3);
      chk(mosi_oe_o, 1'h0, "mosi released");
      wait_on(1);
      chk({rx_fifo_full_flag_o, rx_dma_request_o, irq_o}, 3'h7, "overflow");
      pop_chk(sb);
      rx_enable_bit_clr_i = 1'h1;
      tick(1);
      rx_enable_bit_clr_i = 1'h0;
      wait_on(0);
      chk(rx_fifo_overflow_flag_o, 1'h1, "sticky");
      stop();
      chk(rx_fifo_overflow_flag_o, 1'h0, "rx reset");
      // Receive only with dummy ones on the line
      idle_output_hiz_i = 1'h0;
      cfg(1'h0, 1'h1);
      base = words;
      go(1'h0, 1'h1);
      wait_on(4);
      chk({mosi_oe_o, sl_rx}, 9'h1FF, "dummy word");
      stop();
      test_done();
   end
endmodule : spi_port_master_tb
